// File: hw/mbpt_top.v
// Purpose: Timer/counter with prescaler, seven matches and pulse outputs
// Assumes: Classic Wishbone slave, one clock, async high reset
// Notes: Matches act on the tick that moves the counter off the value
// How it works
// - The counter advances on prescaled clocks or on capture pin edges.
// - Seven match registers serve up to six single or five double outputs.
// - The cycle period match restarts the counter from zero.
// - A single-edge output rises on the period match, falls on its own.
// - Single-edge outputs rise each cycle unless set to stay low.
// - A double-edge output is set and cleared by two independent matches.
// - Each output uses one or two match registers and the shared period.
// - Each match may continue, stop or reset, optionally flagging an event.
// - In pulse mode, match values take effect only after release, at a cycle start.
// - Period and width are any whole number of counts.
// - With pulse mode off the block is a plain 32-bit timer.
// - The block runs from the one clock input, clk, that also times the bus.
`timescale 1ns/1ps
`include "mbpt_defs.vh"
module mbpt_top (
  clk,
  rst,
  wb_cyc_i,
  wb_stb_i,
  wb_we_i,
  wb_adr_i,
  wb_sel_i,
  wb_dat_i,
  wb_dat_o,
  wb_ack_o,
  cap_in,
  pwm_out,
  irq
);
  input wire clk;
  input wire rst;
  input wire wb_cyc_i;
  input wire wb_stb_i;
  input wire wb_we_i;
  input wire [7:0] wb_adr_i;
  input wire [3:0] wb_sel_i;
  input wire [31:0] wb_dat_i;
  output wire [31:0] wb_dat_o;
  output wire wb_ack_o;
  input wire [1:0] cap_in;
  output wire [6:1] pwm_out;
  output wire irq;

  reg ack_q;
  reg [31:0] rdat_q;
  reg [31:0] rdat_d;
  reg [6:0] flag_q;
  reg [3:0] ctrl_q;
  reg [31:0] tc_q;
  reg [31:0] pr_q;
  reg [31:0] pc_q;
  reg [20:0] mact_q;
  reg [3:0] src_q;
  reg [14:0] ocfg_q;
  reg [6:0] rel_q;
  reg [6:1] pwm_q;
  reg irq_q;
  reg [31:0] mr_q [0:6];
  reg [31:0] sh_q [0:6];

  wire req;
  wire wr;
  wire [1:0] rise;
  wire [1:0] fall;
  wire [6:0] match;
  wire [6:0] hit_rst;
  wire [6:0] hit_stop;
  wire [6:0] hit_int;
  wire [6:0] mr_wr;
  wire cap_rise;
  wire cap_fall;
  wire src_ev;
  wire run;
  wire tick;
  wire pwm_en;
  wire cycle_start;
  wire [31:0] mact_new;
  wire [31:0] ocfg_new;
  wire [7:0] moff;

  // Byte lane merge for partial writes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] sel;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (sel[b]) begin
          merge[8*b +: 8] = nw[8*b +: 8];
        end
      end
    end
  endfunction

  assign req = wb_cyc_i & wb_stb_i;
  // Write lands on the edge where the master sees ack
  assign wr = req & wb_we_i & ack_q;
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign pwm_out = pwm_q;
  assign irq = irq_q;
  assign mact_new = merge({11'h000, mact_q}, wb_dat_i, wb_sel_i);
  assign ocfg_new = merge({17'h0_0000, ocfg_q}, wb_dat_i, wb_sel_i);
  assign moff = wb_adr_i - `MBPT_A_MATCH0;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_cap
      mbpt_edge_sync u_sync (
        .clk(clk),
        .rst(rst),
        .pin(cap_in[g]),
        .rise(rise[g]),
        .fall(fall[g])
      );
    end
  endgenerate

  assign cap_rise = rise[src_q[2]];
  assign cap_fall = fall[src_q[2]];
  // Count source: every clock, or chosen edges of a capture pin
  assign src_ev = (src_q[1:0] == `MBPT_SRC_TIMER) ? 1'b1 :
    (src_q[1:0] == `MBPT_SRC_RISE) ? cap_rise :
    (src_q[1:0] == `MBPT_SRC_FALL) ? cap_fall :
    (cap_rise | cap_fall);
  assign run = ctrl_q[`MBPT_CTRL_EN] & ~ctrl_q[`MBPT_CTRL_RST];
  assign tick = run & src_ev & (pc_q == pr_q);
  assign pwm_en = ctrl_q[`MBPT_CTRL_PWM];

  generate
    for (g = 0; g < `MBPT_NUM_MATCH; g = g + 1) begin : g_match
      localparam integer MOFS = 4 * g;
      // Any 32-bit value is a legal match point
      assign match[g] = tick & (tc_q == mr_q[g]);
      assign hit_rst[g] = match[g] & mact_q[3*g + `MBPT_MACT_RST];
      assign hit_stop[g] = match[g] & mact_q[3*g + `MBPT_MACT_STOP];
      assign hit_int[g] = match[g] & mact_q[3*g + `MBPT_MACT_INT];
      assign mr_wr[g] = wr &
        (wb_adr_i == `MBPT_A_MATCH0 + MOFS[7:0]);
    end
  endgenerate

  // Start of a pulse cycle: the period match while pulse mode runs
  assign cycle_start = pwm_en & match[0];

  generate
    for (g = 0; g < `MBPT_NUM_MATCH; g = g + 1) begin : g_mreg
      // Shadow takes writes; active copy moves on release, or on the write itself with pulse mode off
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          sh_q[g] <= `MBPT_ZERO32;
          mr_q[g] <= `MBPT_ZERO32;
        end else begin
          if (mr_wr[g]) begin
            sh_q[g] <= merge(sh_q[g], wb_dat_i, wb_sel_i);
          end
          if (!pwm_en) begin
            if (mr_wr[g]) begin
              mr_q[g] <= merge(sh_q[g], wb_dat_i, wb_sel_i);
            end
          end else if (cycle_start & rel_q[g]) begin
            mr_q[g] <= sh_q[g];
          end
        end
      end
    end
  endgenerate

  // Release bits clear once consumed; a new write wins
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rel_q <= 7'h00;
    end else if (wr & (wb_adr_i == `MBPT_A_RELEASE) & wb_sel_i[0]) begin
      rel_q <= (cycle_start ? 7'h00 : rel_q) | wb_dat_i[6:0];
    end else if (cycle_start) begin
      rel_q <= 7'h00;
    end
  end

  // Prescaler and counter
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pc_q <= `MBPT_ZERO32;
      tc_q <= `MBPT_ZERO32;
    end else if (ctrl_q[`MBPT_CTRL_RST]) begin
      pc_q <= `MBPT_ZERO32;
      tc_q <= `MBPT_ZERO32;
    end else begin
      if (wr & (wb_adr_i == `MBPT_A_COUNT)) begin
        tc_q <= merge(tc_q, wb_dat_i, wb_sel_i);
      end else if (tick) begin
        if (|hit_rst) begin
          tc_q <= `MBPT_ZERO32;
        end else if (!(|hit_stop)) begin
          tc_q <= tc_q + 32'h0000_0001;
        end
      end
      if (run & src_ev) begin
        pc_q <= tick ? `MBPT_ZERO32 : pc_q + 32'h0000_0001;
      end
    end
  end

  // Control, prescale limit, actions, source and output setup
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= `MBPT_CTRL_RESET;
      pr_q <= `MBPT_ZERO32;
      mact_q <= 21'h00_0000;
      src_q <= 4'h0;
      ocfg_q <= 15'h0000;
    end else begin
      if (wr & (wb_adr_i == `MBPT_A_CTRL) & wb_sel_i[0]) begin
        ctrl_q <= wb_dat_i[3:0];
      end else if (|hit_stop) begin
        ctrl_q[`MBPT_CTRL_EN] <= 1'b0;
      end
      if (wr & (wb_adr_i == `MBPT_A_PRESCALE)) begin
        pr_q <= merge(pr_q, wb_dat_i, wb_sel_i);
      end
      if (wr & (wb_adr_i == `MBPT_A_MACTION)) begin
        mact_q <= mact_new[20:0];
      end
      if (wr & (wb_adr_i == `MBPT_A_SOURCE) & wb_sel_i[0]) begin
        src_q <= wb_dat_i[3:0];
      end
      if (wr & (wb_adr_i == `MBPT_A_OUTCFG)) begin
        ocfg_q <= ocfg_new[14:0];
      end
    end
  end

  // Event flags: hardware set wins over a write-one clear
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_q <= 7'h00;
      irq_q <= 1'b0;
    end else begin
      if (wr & (wb_adr_i == `MBPT_A_FLAGS) & wb_sel_i[0]) begin
        flag_q <= (flag_q & ~wb_dat_i[6:0]) | hit_int;
      end else begin
        flag_q <= flag_q | hit_int;
      end
      irq_q <= |flag_q;
    end
  end

  // Pulse outputs; output 1 is always single edge
  generate
    for (g = 1; g <= `MBPT_NUM_OUT; g = g + 1) begin : g_out
      wire dbl;
      wire set_ev;
      wire clr_ev;
      if (g == 1) begin : g_single
        assign dbl = 1'b0;
      end else begin : g_sel
        assign dbl = ocfg_q[`MBPT_OCFG_DBL_LO + g - 2];
      end
      // Single: set at period match; double: set by previous match
      assign set_ev = dbl ? match[g-1] : match[0];
      assign clr_ev = match[g];
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          pwm_q[g] <= 1'b0;
        end else if (!pwm_en | !ocfg_q[`MBPT_OCFG_ENA_LO + g - 1]) begin
          pwm_q[g] <= 1'b0;
        end else if (clr_ev) begin
          // Clear beats set: an edge match equal to the period match stays low
          pwm_q[g] <= 1'b0;
        end else if (set_ev) begin
          pwm_q[g] <= 1'b1;
        end
      end
    end
  endgenerate

  // Register read mux
  always @* begin
    rdat_d = `MBPT_ZERO32;
    case (wb_adr_i)
      `MBPT_A_FLAGS: rdat_d = {25'h000_0000, flag_q};
      `MBPT_A_CTRL: rdat_d = {28'h000_0000, ctrl_q};
      `MBPT_A_COUNT: rdat_d = tc_q;
      `MBPT_A_PRESCALE: rdat_d = pr_q;
      `MBPT_A_PRECOUNT: rdat_d = pc_q;
      `MBPT_A_MACTION: rdat_d = {11'h000, mact_q};
      `MBPT_A_SOURCE: rdat_d = {28'h000_0000, src_q};
      `MBPT_A_OUTCFG: rdat_d = {17'h0_0000, ocfg_q};
      `MBPT_A_RELEASE: rdat_d = {25'h000_0000, rel_q};
      default: begin
        if (wb_adr_i >= `MBPT_A_MATCH0 && wb_adr_i <= `MBPT_A_MATCH6
            && wb_adr_i[1:0] == 2'h0) begin
          rdat_d = sh_q[moff[4:2]];
        end
      end
    endcase
  end

  // One-cycle ack for every address, unmapped ones read zero
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
      rdat_q <= `MBPT_ZERO32;
    end else begin
      ack_q <= req & ~ack_q;
      if (req & ~ack_q) begin
        rdat_q <= rdat_d;
      end
    end
  end
endmodule // mbpt_top

// File: include/mbpt_defs.vh
// Purpose: Constants for the match based pulse width timer
// Assumes: Byte addresses on a 32-bit Wishbone bus
// Notes: Definitions only
`ifndef MBPT_DEFS_VH
`define MBPT_DEFS_VH
`define MBPT_NUM_MATCH 7
`define MBPT_NUM_OUT 6
`define MBPT_A_FLAGS 8'h00
`define MBPT_A_CTRL 8'h04
`define MBPT_A_COUNT 8'h08
`define MBPT_A_PRESCALE 8'h0C
`define MBPT_A_PRECOUNT 8'h10
`define MBPT_A_MACTION 8'h14
`define MBPT_A_MATCH0 8'h18
`define MBPT_A_MATCH6 8'h30
`define MBPT_A_SOURCE 8'h34
`define MBPT_A_OUTCFG 8'h38
`define MBPT_A_RELEASE 8'h3C
`define MBPT_CTRL_EN 0
`define MBPT_CTRL_RST 1
`define MBPT_CTRL_PWM 3
`define MBPT_CTRL_RESET 4'h0
`define MBPT_MACT_INT 0
`define MBPT_MACT_RST 1
`define MBPT_MACT_STOP 2
`define MBPT_SRC_TIMER 2'h0
`define MBPT_SRC_RISE 2'h1
`define MBPT_SRC_FALL 2'h2
`define MBPT_SRC_BOTH 2'h3
`define MBPT_OCFG_DBL_LO 2
`define MBPT_OCFG_ENA_LO 9
`define MBPT_ZERO32 32'h0000_0000
`endif

// File: hw/mbpt_edge_sync.v
// Purpose: Synchronise one capture pin and report its edges
// Assumes: Pin is asynchronous to clk
// Notes: Edge pulses come in the same cycle as the synchronised level moves
`timescale 1ns/1ps
module mbpt_edge_sync (
  clk,
  rst,
  pin,
  rise,
  fall
);
  input wire clk;
  input wire rst;
  input wire pin;
  output wire rise;
  output wire fall;
  reg meta_q;
  reg sync_q;
  reg last_q;
  // First stage is read by the second stage only
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end
  assign rise = sync_q & ~last_q;
  assign fall = ~sync_q & last_q;
endmodule // mbpt_edge_sync

// File: verification/mbpt_chk_sva.sv
// Purpose: Port-level checks of the pulse width timer
// Assumes: Bus writes use all four byte lanes
// Notes: Pulse mode and output enables are tracked from bus writes
`timescale 1ns/1ps
`include "mbpt_defs.vh"
module mbpt_chk (
  input wire clk,
  input wire rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire [6:1] pwm_out
);
  reg mode_q;
  reg [5:0] en_q;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_q <= 1'b0;
      en_q <= 6'h00;
    end else if (wb_ack_o && wb_we_i && wb_sel_i == 4'hF) begin
      if (wb_adr_i == `MBPT_A_CTRL) mode_q <= wb_dat_i[`MBPT_CTRL_PWM];
      if (wb_adr_i == `MBPT_A_OUTCFG) en_q <= wb_dat_i[14:9];
    end
  end
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence void_rd_s;
    wb_ack_o && !wb_we_i && wb_adr_i > `MBPT_A_RELEASE;
  endsequence
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ack_answer_a: assert property (req_s |=> wb_ack_o)
    else $error("no ack one cycle after a request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a prior request");
  ack_in_req_a: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i)
    else $error("ack outside a request");
  void_read_a: assert property (void_rd_s |-> wb_dat_o == `MBPT_ZERO32)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!(wb_cyc_i && wb_stb_i) |=> $stable(wb_dat_o))
    else $error("read data moved while idle");
  pwm_mode_a: assert property (!mode_q && !$past(mode_q) |-> pwm_out == 6'h00)
    else $error("pulse output with pulse mode off");
  pwm_enable_a: assert property ((pwm_out & ~en_q & ~$past(en_q)) == 6'h00)
    else $error("disabled pulse output high");
endmodule // mbpt_chk
bind mbpt_top mbpt_chk u_chk (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pwm_out);

// File: verification/mbpt_load.sv
// Purpose: Load model counting high cycles on each pulse pin
// Assumes: Pins are registered outputs, stable at the rising edge
// Notes: Counts clear while meas is low
`timescale 1ns/1ps
module mbpt_load (
  input wire clk,
  input wire meas,
  input wire [6:1] pwm_out,
  output logic [5:0][7:0] hi
);
  always @(posedge clk) begin
    for (int k = 0; k < 6; k++) begin
      if (!meas) hi[k] <= 8'h00;
      else hi[k] <= hi[k] + {7'h00, pwm_out[k + 1]};
    end
  end
endmodule // mbpt_load

// File: verification/tb_top.sv
// Purpose: Self-checking bench for the pulse width timer
// Assumes: One bus access at a time, all byte lanes
// Notes: Windows span two whole periods so phase does not matter
`timescale 1ns/1ps
`include "mbpt_defs.vh"
module tb_top;
  logic clk, rst, cyc, stb, we, ack, irq, meas;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, d;
  logic [1:0] cap;
  logic [6:1] pwm;
  logic [5:0][7:0] hi;
  logic [31:0] mv [0:5] = '{32'h9, 32'h3, 32'h2, 32'h7, 32'h2, 32'h9};
  int n_errors = 0, n_checks = 0, cycles = 0;
  mbpt_top DUT (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .cap_in(cap), .pwm_out(pwm),
    .irq(irq));
  mbpt_load u_load (.clk(clk), .meas(meas), .pwm_out(pwm), .hi(hi));
  always #5 clk = ~clk;
  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a,
    input logic [31:0] wd);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= wd;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    d = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Two periods of ten clocks; expected high counts per pin
  task automatic measure(input logic [5:0][7:0] e);
    repeat (25) @(posedge clk);
    meas <= 1'b1;
    repeat (20) @(posedge clk);
    meas <= 1'b0;
    @(negedge clk);
    for (int k = 0; k < 6; k++) chk({24'h0, hi[k]}, {24'h0, e[k]});
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      n_errors++;
      give_verdict();
    end
  end
  initial begin
    {clk, cyc, stb, we, meas, cap, adr, wdat} = '0;
    rst = 1'b1;
    sel = 4'hF;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    acc(1, `MBPT_A_PRESCALE, 32'h2);
    acc(1, `MBPT_A_MATCH0, 32'h5);
    acc(1, `MBPT_A_MACTION, 32'h5);
    acc(1, `MBPT_A_CTRL, 32'h1);
    repeat (8) @(posedge clk);
    acc(0, `MBPT_A_COUNT, 32'h0);
    chk({31'h0, d >= 2 && d <= 4}, 32'h1);
    repeat (30) @(posedge clk);
    acc(0, `MBPT_A_COUNT, 32'h0);
    chk(d, 32'h5);
    acc(0, `MBPT_A_CTRL, 32'h0);
    chk(d, 32'h0);
    acc(0, `MBPT_A_FLAGS, 32'h0);
    chk(d, 32'h1);
    chk({31'h0, irq}, 32'h1);
    acc(1, `MBPT_A_FLAGS, 32'h1);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    acc(1, 8'h40, 32'hFFFF_FFFF);
    acc(0, 8'h40, 32'h0);
    chk(d, 32'h0);
    acc(1, `MBPT_A_MACTION, 32'h0);
    acc(1, `MBPT_A_PRESCALE, 32'h0);
    for (int s = 1; s < 4; s++) begin
      acc(1, `MBPT_A_CTRL, 32'h0);
      acc(1, `MBPT_A_COUNT, 32'h0);
      acc(1, `MBPT_A_SOURCE, 32'(s));
      acc(1, `MBPT_A_CTRL, 32'h1);
      repeat (4) begin
        @(posedge clk) cap <= 2'h1;
        repeat (4) @(posedge clk);
        cap <= 2'h0;
        repeat (4) @(posedge clk);
      end
      repeat (4) @(posedge clk);
      acc(0, `MBPT_A_COUNT, 32'h0);
      chk(d, s == 3 ? 32'h8 : 32'h4);
    end
    acc(1, `MBPT_A_CTRL, 32'h0);
    acc(1, `MBPT_A_COUNT, 32'h0);
    acc(1, `MBPT_A_SOURCE, 32'h0);
    for (int k = 0; k < 6; k++) acc(1, 8'(`MBPT_A_MATCH0 + 4 * k), mv[k]);
    acc(1, `MBPT_A_MACTION, 32'h2);
    acc(1, `MBPT_A_OUTCFG, 32'h3E18);
    acc(1, `MBPT_A_RELEASE, 32'h3F);
    acc(1, `MBPT_A_CTRL, 32'h9);
    measure(48'h00_00_0A_0A_06_08);
    acc(1, `MBPT_A_MATCH0 + 8'h04, 32'h6);
    measure(48'h00_00_0A_0A_06_08);
    acc(0, `MBPT_A_MATCH0 + 8'h04, 32'h0);
    chk(d, 32'h6);
    acc(1, `MBPT_A_RELEASE, 32'h2);
    measure(48'h00_00_0A_0A_06_0E);
    give_verdict();
  end
endmodule // tb_top
